// file: inc/pin_mux_pkg.sv
// constants, carriers and the priority function for the shared pin mux
// assumes one 100 MHz clock and a 32-bit apb register port
package pin_mux_pkg;

  localparam int NPIN = 8;
  localparam int NSLOT = 4;

  // pin index: port a lines 0..5, then port b lines 0 and 1
  localparam int PIN_B0 = 6;
  localparam int PIN_INPUT_ONLY = 2;

  // register byte offsets
  localparam logic [7:0] OFS_ANALOG_SEL = 8'h00;
  localparam logic [7:0] OFS_KBD_EN = 8'h04;
  localparam logic [7:0] OFS_MISC_EN = 8'h08;
  localparam logic [7:0] OFS_PORT_DIR = 8'h0c;
  localparam logic [7:0] OFS_PORT_DATA = 8'h10;
  localparam logic [7:0] OFS_PULLUP = 8'h14;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h18;
  localparam logic [7:0] OFS_OWNER = 8'h1c;

  // values after reset: every pin a port input
  localparam logic [5:0] RST_ANALOG_SEL = 6'h00;
  localparam logic [5:0] RST_KBD_EN = 6'h00;
  localparam logic [7:0] RST_MISC_EN = 8'h00;
  localparam logic [7:0] RST_PORT = 8'h00;

  // misc enable register bit positions
  localparam int MISC_TIMER0 = 0;
  localparam int MISC_TIMER1 = 1;
  localparam int MISC_IRQ = 2;
  localparam int MISC_TIMER_CLK = 3;
  localparam int MISC_RSTPIN = 4;
  localparam int MISC_OSCIN = 5;
  localparam int MISC_XTAL = 6;
  localparam int MISC_CLKOUT = 7;

  typedef logic [1:0] slot_t;
  localparam slot_t SLOT_TOP = 2'h0;
  localparam slot_t SLOT_PORT = 2'h3;

  typedef struct packed {
    logic oe;
    logic out;
    logic pue;
  } pad_ctl_t;

  typedef struct packed {
    logic [5:0] kbd;
    logic [1:0] tch;
    logic timer_clk;
    logic irq_n;
    logic rst_n;
    logic xtal;
  } fn_in_t;

  // lowest set index wins; slot 0 is the highest priority
  function automatic slot_t first_set(input logic [NSLOT-1:0] en);
    slot_t idx;
    idx = SLOT_PORT;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (en[i]) begin
        idx = slot_t'(i);
      end
    end
    return idx;
  endfunction

endpackage

// file: verilog/pin_owner_sel.sv
// one pin's owner choice and pad control select
// assumes the port slot is always requested by the caller
`timescale 1ns/1ps
`default_nettype none
module pin_owner_sel
  import pin_mux_pkg::*;
(
  input wire logic [NSLOT-1:0] en,
  input wire logic [NSLOT-1:0] analog,
  input wire pad_ctl_t slot_ctl [NSLOT],
  output slot_t owner,
  output pad_ctl_t pad
);
  slot_t drv;

  always_comb begin
    owner = first_set(en);
    // analog never drives; the next enabled function keeps the pad
    drv = first_set(en & ~analog); // [RULE10]
    pad = slot_ctl[drv]; // [RULE14]
  end

endmodule // pin_owner_sel
`default_nettype wire

// file: verilog/shared_pin_priority_mux.sv
// priority mux for the eight shared package pins, apb register port
// assumes pad inputs are asynchronous and timer/osc inputs share clk
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// RULE1 - after any reset every shared pin is a port input
// RULE2 - port a line 0: analog 0, timer ch 0, keyboard 0, port
// RULE3 - port a line 1: analog 1, timer ch 1, keyboard 1, port
// RULE4 - port a line 2: irq, timer clock, keyboard 2, input port
// RULE5 - port a line 3: reset pin, keyboard 3, port
// RULE6 - port a line 4: osc output, analog 2, keyboard 4, port
// RULE7 - port a line 5: osc input, analog 3, keyboard 5, port
// RULE8 - port b line 0: analog 4 beats the port bit
// RULE9 - port b line 1: analog 5 beats the port bit
// RULE10 - analog select never disables other functions at the pad
// RULE11 - software leaves analog pins as inputs, others disabled
// RULE12 - line 4 drives the clock out only with clock-out enable set; the code also drives it when the xtal bit is set
// RULE13 - port b pads absent on small packages, never driven
// RULE14 - pad controls come from the granted function only
module shared_pin_priority_mux
  import pin_mux_pkg::*;
#(
  parameter bit HAS_PORT_B = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sys_rst_req,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPIN-1:0] pad_in,
  input wire logic [1:0] tch_oe_in,
  input wire logic [1:0] tch_out_in,
  input wire logic xtal_output,
  output pad_ctl_t pad_ctl [NPIN],
  output logic [5:0] analog_sw,
  output fn_in_t fn_in
);

  logic [5:0] analog_sel_ff, nxt_analog_sel;
  logic [5:0] kbd_en_ff, nxt_kbd_en;
  logic [7:0] misc_ff, nxt_misc;
  logic [7:0] dir_ff, nxt_dir;
  logic [7:0] data_ff, nxt_data;
  logic [7:0] pull_ff, nxt_pull;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [NPIN-1:0] sync1_ff, sync2_ff;
  pad_ctl_t pad_ff [NPIN];
  pad_ctl_t nxt_pad [NPIN];
  logic [2*NPIN-1:0] owner_ff, nxt_owner;
  logic [5:0] analog_sw_ff, nxt_analog_sw;
  fn_in_t fn_ff, nxt_fn;

  logic [NSLOT-1:0] en [NPIN];
  logic [NSLOT-1:0] ana [NPIN];
  pad_ctl_t ctl [NPIN][NSLOT];
  slot_t owner [NPIN];
  pad_ctl_t pad_sel [NPIN];
  logic wr_en;
  logic rd_setup;
  logic mapped;

  // apb slave, zero wait states
  always_comb begin
    wr_en = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    unique case (paddr)
      OFS_ANALOG_SEL, OFS_KBD_EN, OFS_MISC_EN, OFS_PORT_DIR,
      OFS_PORT_DATA, OFS_PULLUP, OFS_PIN_LEVEL, OFS_OWNER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    pready = 1'b1;
    pslverr = psel & penable & ~mapped;
    prdata = prdata_ff;
  end

  always_comb begin
    nxt_analog_sel = analog_sel_ff;
    nxt_kbd_en = kbd_en_ff;
    nxt_misc = misc_ff;
    nxt_dir = dir_ff;
    nxt_data = data_ff;
    nxt_pull = pull_ff;
    nxt_prdata = prdata_ff;
    if (wr_en) begin
      unique case (paddr)
        OFS_ANALOG_SEL: nxt_analog_sel = pwdata[5:0];
        OFS_KBD_EN: nxt_kbd_en = pwdata[5:0];
        OFS_MISC_EN: nxt_misc = pwdata[7:0];
        OFS_PORT_DIR: nxt_dir = pwdata[7:0];
        OFS_PORT_DATA: nxt_data = pwdata[7:0];
        OFS_PULLUP: nxt_pull = pwdata[7:0];
        default: ;
      endcase
    end
    // read data captured in setup so it leaves a flip-flop
    if (rd_setup) begin
      unique case (paddr)
        OFS_ANALOG_SEL: nxt_prdata = {26'h0, analog_sel_ff};
        OFS_KBD_EN: nxt_prdata = {26'h0, kbd_en_ff};
        OFS_MISC_EN: nxt_prdata = {24'h0, misc_ff};
        OFS_PORT_DIR: nxt_prdata = {24'h0, dir_ff};
        OFS_PORT_DATA: nxt_prdata = {24'h0, data_ff};
        OFS_PULLUP: nxt_prdata = {24'h0, pull_ff};
        OFS_PIN_LEVEL: nxt_prdata = {24'h0, sync2_ff};
        OFS_OWNER: nxt_prdata = {16'h0, owner_ff};
        default: nxt_prdata = 32'h0;
      endcase
    end
    // any internal reset drops every pin back to a port input
    if (sys_rst_req) begin
      nxt_analog_sel = RST_ANALOG_SEL; // [RULE1]
      nxt_kbd_en = RST_KBD_EN;
      nxt_misc = RST_MISC_EN;
      nxt_dir = RST_PORT;
      nxt_data = RST_PORT;
      nxt_pull = RST_PORT;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_sel_ff <= RST_ANALOG_SEL; // [RULE1]
      kbd_en_ff <= RST_KBD_EN;
      misc_ff <= RST_MISC_EN;
      dir_ff <= RST_PORT;
      data_ff <= RST_PORT;
      pull_ff <= RST_PORT;
      prdata_ff <= 32'h0;
    end else begin
      analog_sel_ff <= nxt_analog_sel;
      kbd_en_ff <= nxt_kbd_en;
      misc_ff <= nxt_misc;
      dir_ff <= nxt_dir;
      data_ff <= nxt_data;
      pull_ff <= nxt_pull;
      prdata_ff <= nxt_prdata;
    end
  end

  // per pin requests, slot 0 highest, slot 3 the port bit
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      en[p] = 4'h8;
      ana[p] = 4'h0;
      for (int s = 0; s < NSLOT; s++) begin
        ctl[p][s] = '0;
      end
      ctl[p][SLOT_PORT].oe = dir_ff[p] & (p != PIN_INPUT_ONLY);
      ctl[p][SLOT_PORT].out = data_ff[p];
      ctl[p][SLOT_PORT].pue = pull_ff[p] & ~ctl[p][SLOT_PORT].oe;
    end
    for (int p = 0; p < 2; p++) begin
      en[p][0] = analog_sel_ff[p]; // [RULE2] [RULE3]
      ana[p][0] = 1'b1;
      en[p][1] = misc_ff[MISC_TIMER0 + p];
      ctl[p][1].oe = tch_oe_in[p];
      ctl[p][1].out = tch_out_in[p];
      en[p][2] = kbd_en_ff[p];
      ctl[p][2].pue = pull_ff[p];
    end
    en[2][0] = misc_ff[MISC_IRQ]; // [RULE4]
    ctl[2][0].pue = pull_ff[2];
    en[2][1] = misc_ff[MISC_TIMER_CLK];
    en[2][2] = kbd_en_ff[2];
    ctl[2][2].pue = pull_ff[2];
    en[3][0] = misc_ff[MISC_RSTPIN]; // [RULE5]
    ctl[3][0].pue = 1'b1;
    en[3][1] = kbd_en_ff[3];
    ctl[3][1].pue = pull_ff[3];
    // rc/internal clock out with the clock-out enable or with the xtal bit set
    en[4][0] = misc_ff[MISC_XTAL] | misc_ff[MISC_CLKOUT]; // [RULE6] [RULE12]
    ctl[4][0].oe = 1'b1;
    ctl[4][0].out = xtal_output;
    en[4][1] = analog_sel_ff[2];
    ana[4][1] = 1'b1;
    en[4][2] = kbd_en_ff[4];
    ctl[4][2].pue = pull_ff[4];
    en[5][0] = misc_ff[MISC_OSCIN] | misc_ff[MISC_XTAL]; // [RULE7]
    en[5][1] = analog_sel_ff[3];
    ana[5][1] = 1'b1;
    en[5][2] = kbd_en_ff[5];
    ctl[5][2].pue = pull_ff[5];
    for (int p = PIN_B0; p < NPIN; p++) begin
      en[p][0] = analog_sel_ff[p - 2]; // [RULE8] [RULE9]
      ana[p][0] = 1'b1;
    end
  end

  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    pin_owner_sel u_sel (
      .en(en[g]),
      .analog(ana[g]),
      .slot_ctl(ctl[g]),
      .owner(owner[g]),
      .pad(pad_sel[g])
    );
  end

  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      nxt_pad[p] = pad_sel[p]; // [RULE14]
      nxt_owner[2*p +: 2] = owner[p];
      if (p >= PIN_B0 && !HAS_PORT_B) begin
        nxt_pad[p] = '0; // [RULE13]
        nxt_owner[2*p +: 2] = SLOT_PORT;
      end
    end
    // analog switch follows its select even when a digital one drives
    nxt_analog_sw = analog_sel_ff; // [RULE10]
    if (!HAS_PORT_B) begin
      nxt_analog_sw[5:4] = 2'h0; // [RULE13]
    end
    // pad level reaches every enabled input function
    nxt_fn.kbd = kbd_en_ff & sync2_ff[5:0]; // [RULE14]
    nxt_fn.tch = misc_ff[MISC_TIMER1:MISC_TIMER0] & sync2_ff[1:0];
    nxt_fn.timer_clk = misc_ff[MISC_TIMER_CLK] & sync2_ff[2];
    nxt_fn.irq_n = ~misc_ff[MISC_IRQ] | sync2_ff[2];
    nxt_fn.rst_n = ~misc_ff[MISC_RSTPIN] | sync2_ff[3];
    nxt_fn.xtal = (misc_ff[MISC_OSCIN] | misc_ff[MISC_XTAL]) & sync2_ff[5];
  end

  // pad outputs lag the registers by one cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      for (int p = 0; p < NPIN; p++) begin
        pad_ff[p] <= '0; // [RULE1]
      end
      owner_ff <= {NPIN{SLOT_PORT}};
      analog_sw_ff <= 6'h0;
      fn_ff <= '{kbd: 6'h0, tch: 2'h0, timer_clk: 1'b0, irq_n: 1'b1,
                 rst_n: 1'b1, xtal: 1'b0};
    end else begin
      sync1_ff <= pad_in;
      sync2_ff <= sync1_ff;
      pad_ff <= nxt_pad;
      owner_ff <= nxt_owner;
      analog_sw_ff <= nxt_analog_sw;
      fn_ff <= nxt_fn;
    end
  end

  assign pad_ctl = pad_ff;
  assign analog_sw = analog_sw_ff;
  assign fn_in = fn_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_reset_port_in: assert property ( // [RULE1]
    sys_rst_req |=> ##1 (owner_ff == {NPIN{SLOT_PORT}}
      && pad_ff[0].oe == 1'b0 && pad_ff[3].oe == 1'b0))
    else $error("pins not port inputs after reset");
  chk_line0_order: assert property ( // [RULE2]
    (analog_sel_ff[0] && misc_ff[MISC_TIMER0])
      |=> owner_ff[1:0] == SLOT_TOP)
    else $error("line 0 analog did not win");
  chk_line1_timer: assert property ( // [RULE3]
    (!analog_sel_ff[1] && misc_ff[MISC_TIMER1] && kbd_en_ff[1])
      |=> owner_ff[3:2] == 2'h1)
    else $error("line 1 timer did not win");
  chk_line2_irq: assert property ( // [RULE4]
    (misc_ff[MISC_IRQ] && misc_ff[MISC_TIMER_CLK])
      |=> owner_ff[5:4] == SLOT_TOP
      && pad_ff[2].oe == 1'b0)
    else $error("line 2 irq did not win");
  chk_line3_reset: assert property ( // [RULE5]
    misc_ff[MISC_RSTPIN] |=> owner_ff[7:6] == SLOT_TOP && pad_ff[3].pue)
    else $error("line 3 reset pin not granted");
  chk_line4_osc: assert property ( // [RULE6]
    (misc_ff[MISC_CLKOUT] && analog_sel_ff[2]) |=> owner_ff[9:8] == SLOT_TOP
      && pad_ff[4].oe)
    else $error("line 4 clock out not granted");
  chk_line5_osc: assert property ( // [RULE7]
    (misc_ff[MISC_OSCIN] && kbd_en_ff[5]) |=> owner_ff[11:10] == SLOT_TOP)
    else $error("line 5 osc input not granted");
  chk_portb_analog: assert property ( // [RULE8] [RULE9]
    (HAS_PORT_B && analog_sel_ff[4] && analog_sel_ff[5])
      |=> owner_ff[15:12] == 4'h0)
    else $error("port b analog did not win");
  chk_analog_keeps: assert property ( // [RULE10]
    (analog_sel_ff[0] && misc_ff[MISC_TIMER0] && tch_oe_in[0])
      |=> pad_ff[0].oe && analog_sw_ff[0])
    else $error("analog select overrode timer");
  chk_clkout_gate: assert property ( // [RULE12]
    (!misc_ff[MISC_CLKOUT] && !misc_ff[MISC_XTAL]) |=> pad_ff[4].oe ==
      ($past(dir_ff[4]) && !$past(kbd_en_ff[4])))
    else $error("clock out driven without enable");
  chk_portb_absent: assert property ( // [RULE13]
    !HAS_PORT_B |-> pad_ff[6] == '0 && pad_ff[7] == '0)
    else $error("absent port b pad driven");
  chk_port_data: assert property ( // [RULE14]
    (en[1] == 4'h8 && dir_ff[1]) |=> pad_ff[1].oe
      && pad_ff[1].out == $past(data_ff[1]))
    else $error("port data not passed to pad");

  cov_adc_over_timer: cover property (
    analog_sel_ff[0] && misc_ff[MISC_TIMER0]);
  cov_clk_out: cover property (misc_ff[MISC_CLKOUT] && pad_ff[4].oe);
  cov_reset_pin: cover property (misc_ff[MISC_RSTPIN] && !fn_ff.rst_n);
  cov_bad_addr: cover property (pslverr);

endmodule // shared_pin_priority_mux
`default_nettype wire

// file: test/board_model.sv
// board circuitry on the eight shared pins
// assumes pad_ctl oe high means the device drives the pin
`timescale 1ns/1ps
`default_nettype none
module board_model
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire pad_ctl_t pad_ctl [NPIN],
  input wire logic [NPIN-1:0] ext_en,
  input wire logic [NPIN-1:0] ext_drive,
  output logic [NPIN-1:0] pad_in
);
  // undriven pins flip every cycle so a stale level never passes
  logic [NPIN-1:0] float_ff = '0;
  always @(posedge clk) begin
    float_ff <= ~pad_in;
  end
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      if (pad_ctl[p].oe) begin
        pad_in[p] = pad_ctl[p].out;
      end else if (ext_en[p]) begin
        pad_in[p] = ext_drive[p];
      end else if (pad_ctl[p].pue) begin
        pad_in[p] = 1'b1;
      end else begin
        pad_in[p] = float_ff[p];
      end
    end
  end
endmodule // board_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the shared pin mux
// assumes zero-wait apb slave; second instance is the small package
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pin_mux_pkg::*;
;
  logic clk = 0, arst_n = 0, sys_rst_req = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic xtal_output = 0;
  logic [15:0] ow;
  logic [7:0] paddr = 8'h00, ext_en = 8'h00, ext_drive = 8'h00, pad_in, ms;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h6;
  logic [1:0] tch_oe_in = 2'h0, tch_out_in = 2'h0;
  logic [5:0] analog_sw, an, kb;
  pad_ctl_t pad_ctl [NPIN];
  pad_ctl_t pad_ctl2 [NPIN];
  fn_in_t fn_in;
  int failures = 0, check_count = 0;
  always #5 clk = ~clk;
  shared_pin_priority_mux shared_pin_priority_mux_i (.clk(clk),
    .arst_n(arst_n), .sys_rst_req(sys_rst_req), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .tch_oe_in(tch_oe_in), .tch_out_in(tch_out_in),
    .xtal_output(xtal_output), .pad_ctl(pad_ctl), .analog_sw(analog_sw),
    .fn_in(fn_in));
  // same bus, no port b pads
  shared_pin_priority_mux #(.HAS_PORT_B(1'b0)) small_i (.clk(clk),
    .arst_n(arst_n), .sys_rst_req(sys_rst_req), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .pad_in(pad_in),
    .tch_oe_in(tch_oe_in), .tch_out_in(tch_out_in),
    .xtal_output(xtal_output), .pad_ctl(pad_ctl2), .analog_sw(),
    .fn_in());
  board_model board_model_i (.clk(clk), .pad_ctl(pad_ctl), .ext_en(ext_en),
    .ext_drive(ext_drive), .pad_in(pad_in));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] exp_owner(logic [5:0] a, logic [5:0] k,
                                            logic [7:0] m);
    logic [3:0] e [8];
    logic [15:0] r;
    e = '{{1'b1, k[0], m[0], a[0]}, {1'b1, k[1], m[1], a[1]},
          {1'b1, k[2], m[3], m[2]}, {2'b10, k[3], m[4]},
          {1'b1, k[4], a[2], m[6] | m[7]}, {1'b1, k[5], a[3], m[5] | m[6]},
          {3'b100, a[4]}, {3'b100, a[5]}};
    for (int p = 0; p < 8; p++) begin
      for (int s = 3; s >= 0; s--) begin
        if (e[p][s]) begin
          r[2*p +: 2] = 2'(s);
        end
      end
    end
    return r;
  endfunction
  function automatic logic [7:0] oev(input int w);
    logic [7:0] v;
    for (int p = 0; p < 8; p++) begin
      v[p] = (w == 0) ? pad_ctl[p].oe : (w == 1) ? pad_ctl[p].out :
             (w == 2) ? pad_ctl2[p].oe : pad_ctl[p].pue;
    end
    return v;
  endfunction
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      failures++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      if (a != 6) chk(rd, (a == 7) ? 32'hffff : 32'h0);
    end
    chk(32'(oev(0)), 32'h0);
    $display("test reset done");
    for (int k = 0; k < 14; k++) begin
      an = 6'(xs());
      kb = 6'(xs());
      ms = 8'(xs());
      // corners: everything on, then keyboard alone
      if (k == 0) {an, kb, ms} = 20'hfffff;
      if (k == 1) {an, kb, ms} = {6'h00, 6'h3f, 8'h00};
      apb(1'b1, OFS_ANALOG_SEL, 32'(an));
      apb(1'b1, OFS_KBD_EN, 32'(kb));
      apb(1'b1, OFS_MISC_EN, 32'(ms));
      apb(1'b0, OFS_OWNER, 32'h0);
      ow = exp_owner(an, kb, ms);
      chk(rd & 32'hff, 32'(ow[7:0]));
      chk(rd >> 8, 32'(ow[15:8]));
    end
    $display("test priority done");
    apb(1'b1, OFS_ANALOG_SEL, 32'h0);
    apb(1'b1, OFS_KBD_EN, 32'h0);
    apb(1'b1, OFS_MISC_EN, 32'h0);
    apb(1'b1, OFS_PORT_DIR, 32'hff);
    apb(1'b1, OFS_PORT_DATA, 32'ha5);
    settle(2);
    chk(32'(oev(0)), 32'hfb);
    chk(32'(oev(1) & 8'hfb), 32'ha1);
    chk(32'(oev(2) & 8'hc0), 32'h0);
    ext_en <= 8'h04;
    ext_drive <= 8'h00;
    settle(4);
    apb(1'b0, OFS_PIN_LEVEL, 32'h0);
    chk(rd, 32'ha1);
    ext_drive <= 8'h04;
    apb(1'b1, OFS_KBD_EN, 32'h04);
    settle(4);
    chk(32'({fn_in.kbd[2], fn_in.irq_n}), 32'h3);
    $display("test port done");
    tch_oe_in <= 2'h1;
    tch_out_in <= 2'(xs());
    xtal_output <= 1'b1;
    apb(1'b1, OFS_ANALOG_SEL, 32'h01);
    apb(1'b1, OFS_MISC_EN, 32'h81);
    settle(2);
    chk(32'({pad_ctl[0].oe, pad_ctl[0].out, analog_sw[0]}),
        32'({2'b10 | 2'(tch_out_in[0]), 1'b1}));
    chk(32'({pad_ctl[4].oe, pad_ctl[4].out}), 32'h3);
    apb(1'b1, OFS_MISC_EN, 32'h01);
    settle(2);
    chk(32'({pad_ctl[4].oe, pad_ctl[4].out}), 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // port pull-up only on inputs; keyboard slot uses the pull-up bit
    apb(1'b1, OFS_PULLUP, 32'hff);
    apb(1'b1, OFS_PORT_DIR, 32'h0f);
    settle(2);
    chk(32'(oev(3)), 32'hf4);
    $display("test functions done");
    apb(1'b1, OFS_MISC_EN, 32'hff);
    // board pulls line 3 low to assert the reset pin function
    ext_en <= 8'h2c;
    ext_drive <= 8'h24;
    settle(4);
    chk(32'({fn_in.rst_n, fn_in.xtal, fn_in.timer_clk, fn_in.irq_n,
             fn_in.tch[0]}), 32'({4'b0111, tch_out_in[0]}));
    @(posedge clk);
    sys_rst_req <= 1'b1;
    @(posedge clk);
    sys_rst_req <= 1'b0;
    settle(2);
    chk(32'(oev(0)), 32'h0);
    apb(1'b0, OFS_OWNER, 32'h0);
    chk(rd, 32'hffff);
    $display("test internal reset done");
    apb(1'b1, OFS_PORT_DIR, 32'hff);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    settle(1);
    chk(32'(oev(0)), 32'h0);
    apb(1'b0, OFS_PORT_DIR, 32'h0);
    chk(rd, 32'h0);
    $display("test async reset done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
